// ### byte_fifo.sv
// Purpose: Small show-ahead FIFO holding transmit bytes.
// Assumes: DEPTH is a power of two so the pointers wrap by themselves.
// Notes: Entries are registers, so the head word is muxed from them by rd_ptr_r.
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire logic push = in_valid & in_ready;
    wire logic pop = out_valid & out_ready;

    // ==========================================================
    // Flags and head word
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];

    // One write port per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                mem_r[i] <= '0;
            end else if (push && (wr_ptr_r == AW'(i))) begin
                mem_r[i] <= in_data;
            end
        end
    end

    // Pointers and fill count
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
            if (pop) rd_ptr_r <= rd_ptr_r + AW'(1);
            if (push && !pop) count_r <= count_r + (AW+1)'(1);
            else if (pop && !push) count_r <= count_r - (AW+1)'(1);
        end
    end

endmodule : byte_fifo

// ### spi_master_slave_port.sv
// Purpose: Byte-wide SPI port, master or slave, behind memory-mapped registers.
// Assumes: Pin inputs are synchronous to core_clk; bus strobes last one cycle.
// Notes: Transmit bytes queue in a four-entry FIFO ahead of the shifter.
// Summary of operation
// - Continuous master mode shifts while data queued.
// - Slave select held low across continuous bytes.
// - Single bytes otherwise, stall before next.
// - Loopback feeds serial output into input.
// - Slave data out driven only when enabled.
// - Master drives slave select only when enabled.
// - Overflow overwrites or discards per control bit.
// - Underflow resends previous byte or zero.
// - Transmit-write start, interrupt on transmit empty.
// - Receive-read start, interrupt on receive full.
// - Bit order LSB or MSB first.
// - Clock idles at polarity bit level.
// - Phase bit picks leading or trailing sampling.
// - Master bit selects clock generation role.
// - Port works only while enabled.
// - Read-only eight-bit status, zero after reset.
// - Clock rate is core clock over 2(1+div).
// - Overflow flag set, cleared by receive read.
// - Underflow flag set, cleared by transmit write.
module spi_master_slave_port (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [31:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic tx_space,
    output logic irq,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe_n,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe_n
);
    import spi_port_pkg::*;

    // ==========================================================
    // State
    logic [15:0] ctrl_r;
    logic [7:0] div_r;
    logic [7:0] div_cnt_r;
    logic [3:0] half_cnt_r;
    xfer_state_e state_r;
    xfer_state_e state_nxt;
    logic sclk_r;
    logic ss_n_r;
    logic sclk_prev_r;
    logic ss_prev_r;
    logic start_req_r;
    logic [7:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic [7:0] last_tx_r;
    logic [7:0] rx_data_r;
    logic rx_full_r;
    logic ovf_r;
    logic undr_r;
    logic tx_irq_r;
    logic busy_prev_r;
    logic irq_r;
    logic [15:0] rdata_r;
    logic [7:0] status_w;
    logic fifo_valid;
    logic [7:0] fifo_data;

    // ==========================================================
    // Address decode and strobes
    wire logic sel_status = (bus_addr == ADDR_STATUS);
    wire logic sel_rx = (bus_addr == ADDR_RX);
    wire logic sel_tx = (bus_addr == ADDR_TX);
    wire logic sel_div = (bus_addr == ADDR_DIV);
    wire logic sel_ctrl = (bus_addr == ADDR_CTRL);
    wire logic wr_ctrl = bus_wr & sel_ctrl;
    wire logic wr_div = bus_wr & sel_div;
    wire logic wr_tx = bus_wr & sel_tx;
    wire logic rd_rx = bus_rd & sel_rx;

    // Mode decode
    wire logic en = ctrl_r[C_EN];
    wire logic master_on = en & ctrl_r[C_MASTER];
    wire logic slave_on = en & ~ctrl_r[C_MASTER];
    wire logic cpha = ctrl_r[C_CPHA];
    wire logic cpol = ctrl_r[C_CPOL];
    wire logic lsb_first = ctrl_r[C_LSB];
    wire logic txmode = ctrl_r[C_TXMODE];
    wire logic cont = ctrl_r[C_CONT];

    // ==========================================================
    // Bit clock enable, only counted while a master sequence runs
    wire logic m_run = master_on & (state_r != ST_IDLE);
    wire logic tick = m_run & (div_cnt_r == div_r);
    wire logic [7:0] div_cnt_nxt = (!m_run || tick) ? BYTE_ZERO : div_cnt_r + 8'h01;

    // Edges of the serial clock, own in master, from the pin in slave
    wire logic slave_edge = slave_on & ~ss_n_in & (sclk_in != sclk_prev_r);
    wire logic slave_start = slave_on & ss_prev_r & ~ss_n_in;
    wire logic edge_ev = master_on ? (tick & (state_r == ST_XFER)) : slave_edge;
    wire logic leading = ~half_cnt_r[0];
    wire logic sample_ev = edge_ev & (leading ^ cpha);
    wire logic shift_ok = cpha ? (half_cnt_r != FIRST_EDGE) : (half_cnt_r != LAST_EDGE);
    wire logic shift_ev = edge_ev & ~(leading ^ cpha) & shift_ok;
    wire logic byte_done = edge_ev & (half_cnt_r == LAST_EDGE);

    // Serial data paths
    wire logic tx_bit = lsb_first ? tx_sh_r[0] : tx_sh_r[7];
    wire logic pin_bit = master_on ? miso_in : mosi_in;
    wire logic rx_bit = ctrl_r[C_LOOP] ? tx_bit : pin_bit;
    wire logic [7:0] rx_shifted = lsb_first ? {rx_bit, rx_sh_r[7:1]} : {rx_sh_r[6:0], rx_bit};
    wire logic [7:0] rx_byte = sample_ev ? rx_shifted : rx_sh_r;
    wire logic [7:0] tx_shifted = lsb_first ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};

    // ==========================================================
    // Transfer start conditions and byte loading
    wire logic start_ok = master_on & (txmode ? fifo_valid : start_req_r);
    wire logic stall_end = (state_r == ST_STALL) & tick & (half_cnt_r == STALL_LAST);
    wire logic cont_next = (state_r == ST_XFER) & byte_done & cont & fifo_valid;
    wire logic m_load = ((state_r == ST_IDLE) & start_ok) | cont_next | (stall_end & start_ok);
    wire logic s_load = slave_start | (slave_on & byte_done);
    wire logic load_ev = m_load | s_load;
    wire logic underflow_ev = load_ev & ~fifo_valid;
    wire logic [7:0] under_byte = ctrl_r[C_UNDR] ? last_tx_r : BYTE_ZERO;
    wire logic [7:0] load_byte = fifo_valid ? fifo_data : under_byte;

    // Receive side events
    wire logic over_ev = byte_done & rx_full_r & ~rd_rx;
    wire logic rx_store = byte_done & (~over_ev | ctrl_r[C_OVWR]);

    // Transmit busy: queued data or a byte on the wire
    wire logic on_wire = (state_r == ST_XFER) | (slave_on & ~ss_n_in);
    wire logic tx_busy = fifo_valid | on_wire;
    wire logic rx_irq = rx_full_r | ovf_r;

    // ==========================================================
    // Transmit queue; writes while full are dropped, tx_space warns software
    byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(wr_tx),
        .in_ready(tx_space),
        .in_data(bus_wdata[7:0]),
        .out_valid(fifo_valid),
        .out_ready(load_ev),
        .out_data(fifo_data)
    );

    // ==========================================================
    // Master sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start_ok) state_nxt = ST_XFER;
            end
            ST_XFER: begin
                if (byte_done && !cont_next) begin
                    state_nxt = start_ok ? ST_STALL : ST_IDLE;
                end
            end
            ST_STALL: begin
                if (stall_end) state_nxt = start_ok ? ST_XFER : ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (!master_on) state_nxt = ST_IDLE;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) state_r <= ST_IDLE;
        else state_r <= state_nxt;
    end

    // ==========================================================
    // Control and divider registers; reserved bits never stored
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RESET;
            div_r <= DIV_RESET;
        end else begin
            if (wr_ctrl) ctrl_r <= bus_wdata & CTRL_WMASK;
            if (wr_div) div_r <= bus_wdata[7:0];
        end
    end

    // Divider, edge counter and pin history
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt_r <= BYTE_ZERO;
            half_cnt_r <= FIRST_EDGE;
            sclk_prev_r <= 1'b0;
            ss_prev_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            sclk_prev_r <= sclk_in;
            ss_prev_r <= ss_n_in;
            if (load_ev || (slave_on && ss_n_in) || !en) half_cnt_r <= FIRST_EDGE;
            else if (edge_ev || (tick && state_r == ST_STALL)) half_cnt_r <= half_cnt_r + 4'h1;
        end
    end

    // Serial clock and slave select outputs of the master
    // Clock forced to idle level whenever no byte is running
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_r <= 1'b0;
            ss_n_r <= 1'b1;
        end else begin
            if (state_r != ST_XFER) sclk_r <= cpol;
            else if (tick) sclk_r <= ~sclk_r;
            ss_n_r <= (state_nxt != ST_XFER);
        end
    end

    // Shift registers and last transmitted byte
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_sh_r <= BYTE_ZERO;
            rx_sh_r <= BYTE_ZERO;
            last_tx_r <= BYTE_ZERO;
        end else begin
            if (load_ev) tx_sh_r <= load_byte;
            else if (shift_ev) tx_sh_r <= tx_shifted;
            if (sample_ev) rx_sh_r <= rx_shifted;
            if (load_ev) last_tx_r <= load_byte;
        end
    end

    // Receive register and its flags; a new event beats the read that clears it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_data_r <= BYTE_ZERO;
            rx_full_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            if (rx_store) rx_data_r <= rx_byte;
            rx_full_r <= byte_done | (rx_full_r & ~rd_rx);
            ovf_r <= over_ev | (ovf_r & ~rd_rx);
        end
    end

    // Transmit flags; the empty interrupt fires when the queue and wire drain
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            undr_r <= 1'b0;
            tx_irq_r <= 1'b0;
            busy_prev_r <= 1'b0;
            start_req_r <= 1'b0;
        end else begin
            busy_prev_r <= tx_busy;
            undr_r <= underflow_ev | (undr_r & ~wr_tx);
            if (underflow_ev || (busy_prev_r && !tx_busy)) tx_irq_r <= 1'b1;
            else if (wr_tx || (!en && !tx_busy)) tx_irq_r <= 1'b0;
            if (rd_rx && master_on && !txmode) start_req_r <= 1'b1;
            else if (m_load || !master_on) start_req_r <= 1'b0;
        end
    end

    // ==========================================================
    // Status assembly; unused upper bits read as zero
    always_comb begin
        status_w = STATUS_RESET;
        status_w[S_TXBUSY] = tx_busy;
        status_w[S_TXIRQ] = tx_irq_r;
        status_w[S_UNDR] = undr_r;
        status_w[S_RXFULL] = rx_full_r;
        status_w[S_RXIRQ] = rx_irq;
        status_w[S_OVF] = ovf_r;
    end

    // Read mux; the transmit register is write only and reads zero
    wire logic [15:0] rd_mux = sel_status ? {8'h00, status_w} :
                               sel_rx ? {8'h00, rx_data_r} :
                               sel_div ? {8'h00, div_r} :
                               sel_ctrl ? ctrl_r : 16'h0000;

    // Read data and interrupt come from flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 16'h0000;
            irq_r <= 1'b0;
        end else begin
            if (bus_rd) rdata_r <= rd_mux;
            irq_r <= en & (master_on ? (txmode ? tx_irq_r : rx_irq) : (tx_irq_r | rx_irq));
        end
    end

    // ==========================================================
    // Pin drivers; enables are low while the pin is driven
    assign bus_rdata = rdata_r;
    assign irq = irq_r;
    assign sclk_out = sclk_r;
    assign sclk_oe_n = ~master_on;
    assign mosi_out = tx_bit;
    assign mosi_oe_n = ~master_on;
    assign miso_out = tx_bit;
    assign miso_oe_n = ~(slave_on & ctrl_r[C_SOE]);
    assign ss_n_out = ss_n_r;
    assign ss_n_oe_n = ~(master_on & ctrl_r[C_SSOE]);

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_ss_held_cont: assert property (cont_next |=> !ss_n_out)
        else $error("slave select released between continuous bytes");
    a_cont_no_gap: assert property (cont_next |=> state_r == ST_XFER)
        else $error("continuous transfer stopped with data queued");
    a_single_stall: assert property ((state_r == ST_XFER) && byte_done && !cont_next
        |=> (state_r != ST_XFER) && ss_n_out)
        else $error("single byte mode started next byte without stall");
    a_sclk_idle_lvl: assert property ((state_r != ST_XFER) |=> sclk_r == $past(cpol))
        else $error("serial clock not at idle level between bytes");
    a_role_pins: assert property (master_on |-> !sclk_oe_n && !mosi_oe_n && miso_oe_n)
        else $error("master pin directions wrong");
    a_slave_ss_in: assert property (!ctrl_r[C_MASTER] |-> ss_n_oe_n && sclk_oe_n)
        else $error("slave drives select or clock");
    a_disabled_idle: assert property (!en |=> state_r == ST_IDLE && ss_n_out)
        else $error("disabled port still transferring");
    a_ovf_discard: assert property (over_ev && !ctrl_r[C_OVWR]
        |=> rx_data_r == $past(rx_data_r) && ovf_r)
        else $error("overflow byte not discarded");
    a_undr_zero: assert property (underflow_ev && !ctrl_r[C_UNDR] |=> tx_sh_r == BYTE_ZERO)
        else $error("underflow did not send zero");
    a_undr_flag: assert property (underflow_ev |=> undr_r ##1 (undr_r || $past(wr_tx)))
        else $error("underflow flag not held");
    a_tx_start: assert property ((state_r == ST_IDLE) && master_on && txmode && fifo_valid
        |=> state_r == ST_XFER)
        else $error("transmit write did not start transfer");
    a_ovf_clear: assert property (ovf_r && rd_rx && !over_ev |=> !ovf_r)
        else $error("overflow flag not cleared by receive read");

endmodule : spi_master_slave_port

// ### spi_peer_model.sv
// Purpose: Behavioural SPI slave standing on the far side of the port.
// Assumes: Clock mode 0 only; MSB first on both directions.
// Notes: Released output shows the inverse of its last bit, never a held value.
module spi_peer_model #(
    parameter logic [7:0] PEER_BYTE = 8'hC6
) (
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] cap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;

    // ==========================================================
    // Frame start loads the reply byte
    initial begin
        miso = 1'b0;
        cap = 8'h00;
        sh = 8'h00;
    end
    always @(negedge ss_n) begin
        sh = PEER_BYTE;
        miso <= #2 PEER_BYTE[7];
    end
    // Sample on the leading edge, idle level low
    always @(posedge sclk) if (!ss_n) cap = {cap[6:0], mosi};
    // Shift on the trailing edge, a little late to avoid racing the sampler
    always @(negedge sclk) begin
        if (!ss_n) begin
            sh = {sh[6:0], 1'b0};
            miso <= #2 sh[7];
        end
    end
    // Released line must not keep its last value
    always @(posedge ss_n) miso <= #2 ~miso;
endmodule : spi_peer_model

// ### spi_port_pkg.sv
// Purpose: Shared constants and types for the byte-wide SPI master/slave port.
// Assumes: Registers sit at full 32-bit byte addresses on the processor MMR bus.
// Notes: Bit positions are ints, used only as indices into the register values.
package spi_port_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [31:0] ADDR_STATUS = 32'hFFFF0A00;
    localparam logic [31:0] ADDR_RX = 32'hFFFF0A04;
    localparam logic [31:0] ADDR_TX = 32'hFFFF0A08;
    localparam logic [31:0] ADDR_DIV = 32'hFFFF0A0C;
    localparam logic [31:0] ADDR_CTRL = 32'hFFFF0A10;

    // ==========================================================
    // Reset values and writable bits
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h1FEF; // Bits 15..13 and 4 are reserved
    localparam logic [7:0] DIV_RESET = 8'h1B;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ==========================================================
    // Control register bit positions
    localparam int C_EN = 0;
    localparam int C_MASTER = 1;
    localparam int C_CPHA = 2;
    localparam int C_CPOL = 3;
    localparam int C_LSB = 5;
    localparam int C_TXMODE = 6;
    localparam int C_UNDR = 7;
    localparam int C_OVWR = 8;
    localparam int C_SSOE = 9;
    localparam int C_SOE = 10;
    localparam int C_LOOP = 11;
    localparam int C_CONT = 12;

    // ==========================================================
    // Status register bit positions
    localparam int S_TXBUSY = 0;
    localparam int S_TXIRQ = 1;
    localparam int S_UNDR = 2;
    localparam int S_RXFULL = 3;
    localparam int S_RXIRQ = 4;
    localparam int S_OVF = 5;

    // ==========================================================
    // Timing and sizing
    localparam int CORE_CLK_HZ = 25000000;
    localparam logic [3:0] LAST_EDGE = 4'hF; // Sixteen clock edges per byte
    localparam logic [3:0] FIRST_EDGE = 4'h0;
    localparam logic [3:0] STALL_LAST = 4'h1; // Stall lasts two half bit periods
    localparam int BYTE_W = 8;
    localparam int TX_FIFO_DEPTH = 4;

    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_STALL} xfer_state_e;

endpackage : spi_port_pkg

// ### tb_top.sv
// Purpose: Self-checking bench for the SPI port in master and slave modes.
// Assumes: Register reads answer one cycle after the strobe.
// Notes: Read notes queue up; a negedge watcher compares each answer whose note has c set.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spi_port_pkg::*;
    localparam logic [7:0] PEER = 8'hC6;
    typedef struct {logic c; logic [15:0] e;} note_s;
    note_s q[$];
    note_s n;
    logic core_clk, nrst, bus_wr, bus_rd, rd_took, irq, tx_space;
    logic [31:0] bus_addr, seed;
    logic [15:0] bus_wdata, bus_rdata, d;
    logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
    logic ss_n_out, ss_n_oe_n, peer_miso, sclk_w, mosi_w, miso_w, ss_w;
    logic m_sclk, m_mosi, m_ss_n;
    logic [7:0] cap, tx, a, b, r;
    logic [15:0] modes [3] = '{16'h0243, 16'h0263, 16'h0A43};
    int n_fail = 0, samples_checked = 0, ss_rise = 0, s0;

    // ==========================================================
    // Wire resolution; bench plays external master while the port is slave
    assign sclk_w = sclk_oe_n ? m_sclk : sclk_out;
    assign mosi_w = mosi_oe_n ? m_mosi : mosi_out;
    assign miso_w = miso_oe_n ? peer_miso : miso_out;
    assign ss_w = ss_n_oe_n ? m_ss_n : ss_n_out;

    spi_master_slave_port spi_master_slave_port_i (.core_clk(core_clk), .nrst(nrst),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .tx_space(tx_space), .irq(irq), .sclk_in(sclk_w),
        .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_w),
        .ss_n_out(ss_n_out), .ss_n_oe_n(ss_n_oe_n));
    spi_peer_model #(.PEER_BYTE(PEER)) spi_peer_model_i (.sclk(sclk_w), .ss_n(ss_w),
        .mosi(mosi_w), .miso(peer_miso), .cap(cap));

    // ==========================================================
    // Clock, frame counter and read-answer watcher
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge ss_n_out) ss_rise++;
    always @(posedge core_clk) rd_took <= bus_rd;
    always @(negedge core_clk) begin
        if (rd_took && q.size() > 0) begin
            n = q.pop_front();
            if (n.c) `CHK(bus_rdata, n.e)
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Bit reversal for the LSB-first expectations
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
    endfunction : rev8

    task automatic wr(input logic [31:0] ad, input logic [15:0] v);
        @(posedge core_clk);
        #1 bus_addr = ad;
        bus_wdata = v;
        bus_wr = 1'b1;
        @(posedge core_clk);
        #1 bus_wr = 1'b0;
    endtask : wr

    // Note goes in the queue; the watcher compares the answer when c is set
    task automatic rd(input logic [31:0] ad, input logic c, input logic [15:0] e,
                      output logic [15:0] v);
        @(posedge core_clk);
        #1 bus_addr = ad;
        bus_rd = 1'b1;
        q.push_back('{c, e});
        @(posedge core_clk);
        #1 bus_rd = 1'b0;
        v = bus_rdata;
    endtask : rd

    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    // Polls the busy flag under a bound
    task automatic wait_idle;
        int i;
        for (i = 0; i < 200; i++) begin
            rd(ADDR_STATUS, 1'b0, 16'h0000, d);
            if (d[S_TXBUSY] === 1'b0) return;
        end
        n_fail++;
        finish_test();
    endtask : wait_idle

    // ==========================================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 32'h0;
        bus_wdata = 16'h0;
        seed = 32'hF3EBA8BA;
        m_sclk = 1'b0;
        m_mosi = 1'b0;
        m_ss_n = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 nrst = 1'b1;
        rd(ADDR_STATUS, 1'b1, {8'h00, STATUS_RESET}, d);
        rd(ADDR_DIV, 1'b1, {8'h00, DIV_RESET}, d);
        rd(32'hFFFF0A14, 1'b1, 16'h0000, d);
        wr(ADDR_CTRL, 16'hFFFF);
        rd(ADDR_CTRL, 1'b1, CTRL_WMASK, d);
        wr(ADDR_CTRL, 16'h0000);
        wr(ADDR_DIV, 16'h0001);
        rd(ADDR_DIV, 1'b1, 16'h0001, d);
        // Plain, LSB-first and loopback single bytes
        for (int m = 0; m < 3; m++) begin
            wr(ADDR_CTRL, modes[m]);
            seed = lfsr(seed);
            tx = seed[7:0];
            wr(ADDR_TX, {8'h00, tx});
            wait_idle();
            `CHK(cap, (m == 1) ? rev8(tx) : tx)
            `CHK(ss_n_oe_n, 1'b0)
            `CHK(miso_oe_n, 1'b1)
            `CHK(sclk_out, 1'b0)
            rd(ADDR_STATUS, 1'b1, 16'h001A, d);
            `CHK(irq, 1'b1)
            rd(ADDR_RX, 1'b1, {8'h00, (m == 2) ? tx : (m == 1) ? rev8(PEER) : PEER}, d);
            rd(ADDR_STATUS, 1'b1, 16'h0002, d);
        end
        // Loopback pair: continuous with overwrite, then single bytes with discard
        for (int o = 1; o >= 0; o--) begin
            wr(ADDR_CTRL, o ? 16'h1B43 : 16'h0A43);
            rd(ADDR_RX, 1'b0, 16'h0000, d);
            seed = lfsr(seed);
            a = seed[7:0];
            b = seed[15:8];
            s0 = ss_rise;
            wr(ADDR_TX, {8'h00, a});
            wr(ADDR_TX, {8'h00, b});
            wait_idle();
            `CHK(ss_rise - s0, o ? 1 : 2)
            rd(ADDR_STATUS, 1'b1, 16'h003A, d);
            rd(ADDR_RX, 1'b1, {8'h00, o ? b : a}, d);
        end
        // Slave byte, mode 0 MSB first, framed by the bench
        wr(ADDR_CTRL, 16'h0401);
        seed = lfsr(seed);
        a = seed[7:0];
        b = seed[15:8];
        wr(ADDR_TX, {8'h00, a});
        @(posedge core_clk);
        #1 m_ss_n = 1'b0;
        m_mosi = b[7];
        for (int k = 7; k >= 0; k--) begin
            repeat (2) @(posedge core_clk);
            #1 m_sclk = 1'b1;
            r = {r[6:0], miso_w};
            repeat (2) @(posedge core_clk);
            #1 m_sclk = 1'b0;
            if (k > 0) m_mosi = b[k - 1];
        end
        repeat (2) @(posedge core_clk);
        #1 m_ss_n = 1'b1;
        `CHK(r, a)
        rd(ADDR_RX, 1'b1, {8'h00, b}, d);
        // Receive-read starts in loopback, then underflow resend and zero
        wr(ADDR_CTRL, 16'h0A83);
        seed = lfsr(seed);
        tx = seed[7:0];
        wr(ADDR_TX, {8'h00, tx});
        rd(ADDR_RX, 1'b0, 16'h0000, d);
        wait_idle();
        `CHK(irq, 1'b1)
        rd(ADDR_RX, 1'b1, {8'h00, tx}, d);
        wait_idle();
        rd(ADDR_STATUS, 1'b1, 16'h001E, d);
        wr(ADDR_CTRL, 16'h0A03);
        rd(ADDR_RX, 1'b1, {8'h00, tx}, d);
        wait_idle();
        wr(ADDR_CTRL, 16'h0A43);
        rd(ADDR_RX, 1'b1, 16'h0000, d);
        wr(ADDR_TX, {8'h00, tx});
        rd(ADDR_STATUS, 1'b1, 16'h0001, d);
        wait_idle();
        // Disabled port must stay quiet with data queued
        wr(ADDR_CTRL, 16'h0242);
        s0 = ss_rise;
        wr(ADDR_TX, 16'h00A5);
        repeat (60) @(posedge core_clk);
        `CHK(ss_rise - s0, 0)
        `CHK(ss_n_oe_n, 1'b1)
        `CHK(sclk_out, 1'b0)
        finish_test();
    end
endmodule : tb_top
